// File: rtl/liu_pkg.sv
/*
 * constants, field layouts and carrier types for the line interface
 * alarm and strap control block.
 * assumes a 40 MHz bus clock and byte addresses on an AHB-Lite bus.
 */
`default_nettype none

package liu_pkg;

   localparam int NUM_CH         = 8;
   localparam int ALARM_LIMIT    = 128;    // empty transmit cycles tolerated
   localparam int GAP_W          = 8;      // holds ALARM_LIMIT + 1
   localparam int CLK_MHZ        = 40;
   localparam int HW_RESET_US    = 10;
   localparam int HW_RESET_CYC   = HW_RESET_US * CLK_MHZ;
   localparam int HWRST_W        = 9;
   localparam int TX_DIV_DEFAULT = 26;     // bus clocks per transmit clock

   // register byte offsets
   localparam logic [7:0] REG_GLOBAL   = 8'h00;
   localparam logic [7:0] REG_RX_TERM  = 8'h04;
   localparam logic [7:0] REG_TX_TERM  = 8'h08;
   localparam logic [7:0] REG_ALARM    = 8'h0c;
   localparam logic [7:0] REG_IRQ_STAT = 8'h10;
   localparam logic [7:0] REG_IRQ_MASK = 8'h14;

   // global register fields
   localparam int GC_RX_OVR      = 0;
   localparam int GC_SINGLE_RAIL = 1;
   localparam int GC_GAUGE26     = 2;
   localparam int GC_IMP_LSB     = 3;
   localparam int GC_W           = 5;

   // reset values
   localparam logic [GC_W-1:0]     GLOBAL_RST = 5'h00;
   localparam logic [NUM_CH-1:0]   TERM_RST   = 8'h00;
   localparam logic [2*NUM_CH-1:0] IRQ_RST    = 16'h0000;

   typedef enum logic [1:0] {
      IMP_100 = 2'b00,
      IMP_110 = 2'b01,
      IMP_75  = 2'b10,
      IMP_120 = 2'b11
   } impedance_e;

   typedef struct packed {
      logic       rail_format_select;
      logic       rx_termination_strap;
      logic       tx_termination_strap;
      logic       impedance_code_msb;
      logic       impedance_code_lsb;
      logic       gauge_strap;
   } strap_s;

   typedef struct packed {
      logic              single_rail;
      logic              gauge26;
      impedance_e        impedance;
      logic [NUM_CH-1:0] rx_term_int;
      logic [NUM_CH-1:0] tx_term_int;
   } line_cfg_s;

endpackage

`default_nettype wire

// File: rtl/liu_alarm_strap_control.sv
/*
 * per-channel driver alarm, hardware reset filter, strap decoding,
 * termination override and in-circuit tristate, with an AHB-Lite slave.
 * assumes straps, pulses and reset pin are synchronous to hclk; the
 * transmit clock is modelled as an enable divided from hclk.
 */
`timescale 1ns/100ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
module liu_alarm_strap_control
   import liu_pkg::*;
#(
   parameter int TX_DIV = TX_DIV_DEFAULT
) (
   // clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // ahb-lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic [31:0]            hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // line and board side
   input  wire logic [NUM_CH-1:0] tx_pulse,
   input  wire logic              host_mode,
   input  wire logic              hw_reset_n,
   input  wire logic              in_circuit_tristate_n,
   input  wire strap_s            straps,
   // alarm pins and configuration
   output logic [NUM_CH-1:0]      driver_monitor_alarm,
   output logic [NUM_CH-1:0]      alarm_oe,
   output logic                   irq,
   output logic                   irq_oe,
   output line_cfg_s              line_cfg
);

   localparam int DIV_W = $clog2(TX_DIV);

   logic [DIV_W-1:0]     div_q, div_d;
   logic                 tx_en;
   logic [HWRST_W-1:0]   hwrst_cnt_q, hwrst_cnt_d;
   logic                 soft_rst;
   logic [GAP_W-1:0]     gap_q [NUM_CH];
   logic [GAP_W-1:0]     gap_d [NUM_CH];
   logic [NUM_CH-1:0]    seen_q, seen_d, seen_now;
   logic [NUM_CH-1:0]    alarm_q, alarm_d;
   logic [NUM_CH-1:0]    oe_q, oe_d;
   logic                 irq_q, irq_d, irq_oe_q, irq_oe_d;
   logic [GC_W-1:0]      global_q, global_d;
   logic [NUM_CH-1:0]    rx_reg_q, rx_reg_d, tx_reg_q, tx_reg_d;
   logic [2*NUM_CH-1:0]  stat_q, stat_d, mask_q, mask_d, events;
   line_cfg_s            cfg_q, cfg_d;
   logic                 accept;
   logic                 wr_pend_q, wr_pend_d, rd_pend_q, rd_pend_d;
   logic [7:0]           addr_q, addr_d;
   logic [31:0]          rdata_q, rdata_d;
   logic                 ready_q, ready_d;
   logic                 rx_from_strap;

   //////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      div_d       = div_q;
      hwrst_cnt_d = hwrst_cnt_q;
      seen_d      = seen_q;
      alarm_d     = alarm_q;
      global_d    = global_q;
      rx_reg_d    = rx_reg_q;
      tx_reg_d    = tx_reg_q;
      stat_d      = stat_q;
      mask_d      = mask_q;
      wr_pend_d   = 1'b0;
      rd_pend_d   = 1'b0;
      addr_d      = addr_q;
      rdata_d     = rdata_q;
      ready_d     = 1'b1;
      for (int i = 0; i < NUM_CH; i++) begin
         gap_d[i] = gap_q[i];
      end

      // transmit clock enable
      tx_en = (div_q == DIV_W'(TX_DIV - 1));
      div_d = tx_en ? '0 : div_q + 1'b1;
      // reset pin must stay low beyond the window, short glitches do nothing
      if (hw_reset_n) begin
         hwrst_cnt_d = '0;
      end else if (hwrst_cnt_q != HWRST_W'(HW_RESET_CYC)) begin
         hwrst_cnt_d = hwrst_cnt_q + 1'b1;
      end
      soft_rst = !hw_reset_n && (hwrst_cnt_q == HWRST_W'(HW_RESET_CYC));
      // per-channel pulse monitor; a pulse between enables is held until counted
      seen_now = seen_q | tx_pulse;
      for (int i = 0; i < NUM_CH; i++) begin
         if (tx_en) begin
            seen_d[i] = 1'b0;
            if (seen_now[i]) begin
               gap_d[i]   = '0;
               alarm_d[i] = 1'b0;
            end else if (gap_q[i] != GAP_W'(ALARM_LIMIT + 1)) begin
               gap_d[i] = gap_q[i] + 1'b1;
               if (gap_q[i] == GAP_W'(ALARM_LIMIT)) begin
                  alarm_d[i] = 1'b1;
               end
            end
         end else begin
            seen_d[i] = seen_now[i];
         end
      end
      events = {alarm_q & ~alarm_d, alarm_d & ~alarm_q};
      // ahb address phase
      accept = hsel && htrans[1] && hready;
      if (accept) begin
         addr_d    = haddr[7:0];
         wr_pend_d = hwrite;
         rd_pend_d = !hwrite;
         ready_d   = hwrite;
      end
      // write data phase; status clears by writing ones
      if (wr_pend_q) begin
         case (addr_q)
            REG_GLOBAL:   global_d = hwdata[GC_W-1:0];
            REG_RX_TERM:  rx_reg_d = hwdata[NUM_CH-1:0];
            REG_TX_TERM:  tx_reg_d = hwdata[NUM_CH-1:0];
            REG_IRQ_STAT: stat_d   = stat_q & ~hwdata[2*NUM_CH-1:0];
            REG_IRQ_MASK: mask_d   = hwdata[2*NUM_CH-1:0];
            default:      ;
         endcase
      end
      // new events win over a clear in the same cycle
      stat_d = stat_d | events;

      // read data one cycle after the address so a preceding write is seen
      if (rd_pend_q) begin
         case (addr_q)
            REG_GLOBAL:   rdata_d = {27'h0, global_q};
            REG_RX_TERM:  rdata_d = {24'h0, rx_reg_q};
            REG_TX_TERM:  rdata_d = {24'h0, tx_reg_q};
            REG_ALARM:    rdata_d = {24'h0, alarm_q};
            REG_IRQ_STAT: rdata_d = {16'h0, stat_q};
            REG_IRQ_MASK: rdata_d = {16'h0, mask_q};
            default:      rdata_d = 32'h0;
         endcase
      end

      if (soft_rst) begin
         global_d = GLOBAL_RST;
         rx_reg_d = TERM_RST;
         tx_reg_d = TERM_RST;
         stat_d   = IRQ_RST;
         mask_d   = IRQ_RST;
         seen_d   = '0;
         alarm_d  = '0;
         for (int i = 0; i < NUM_CH; i++) begin
            gap_d[i] = '0;
         end
      end

      irq_d    = |(stat_d & mask_d);
      oe_d     = {NUM_CH{in_circuit_tristate_n}};
      irq_oe_d = in_circuit_tristate_n;

      // effective line configuration
      rx_from_strap = !host_mode || global_q[GC_RX_OVR];
      if (!host_mode) begin
         cfg_d.single_rail = straps.rail_format_select;
         cfg_d.gauge26     = straps.gauge_strap;
         cfg_d.impedance   = impedance_e'({straps.impedance_code_msb,
                                           straps.impedance_code_lsb});
         cfg_d.tx_term_int = {NUM_CH{straps.tx_termination_strap}};
      end else begin
         cfg_d.single_rail = global_q[GC_SINGLE_RAIL];
         cfg_d.gauge26     = global_q[GC_GAUGE26];
         cfg_d.impedance   = impedance_e'(global_q[GC_IMP_LSB +: 2]);
         cfg_d.tx_term_int = tx_reg_q;
      end
      cfg_d.rx_term_int = rx_from_strap ? {NUM_CH{straps.rx_termination_strap}}
                                        : rx_reg_q;
   end

   //////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q       <= '0;
         hwrst_cnt_q <= '0;
         seen_q      <= '0;
         alarm_q     <= '0;
         oe_q        <= '0;
         irq_q       <= 1'b0;
         irq_oe_q    <= 1'b0;
         global_q    <= GLOBAL_RST;
         rx_reg_q    <= TERM_RST;
         tx_reg_q    <= TERM_RST;
         stat_q      <= IRQ_RST;
         mask_q      <= IRQ_RST;
         cfg_q       <= '0;
         wr_pend_q   <= 1'b0;
         rd_pend_q   <= 1'b0;
         addr_q      <= 8'h00;
         rdata_q     <= 32'h0;
         ready_q     <= 1'b1;
         for (int i = 0; i < NUM_CH; i++) begin
            gap_q[i] <= '0;
         end
      end else begin
         div_q       <= div_d;
         hwrst_cnt_q <= hwrst_cnt_d;
         seen_q      <= seen_d;
         alarm_q     <= alarm_d;
         oe_q        <= oe_d;
         irq_q       <= irq_d;
         irq_oe_q    <= irq_oe_d;
         global_q    <= global_d;
         rx_reg_q    <= rx_reg_d;
         tx_reg_q    <= tx_reg_d;
         stat_q      <= stat_d;
         mask_q      <= mask_d;
         cfg_q       <= cfg_d;
         wr_pend_q   <= wr_pend_d;
         rd_pend_q   <= rd_pend_d;
         addr_q      <= addr_d;
         rdata_q     <= rdata_d;
         ready_q     <= ready_d;
         for (int i = 0; i < NUM_CH; i++) begin
            gap_q[i] <= gap_d[i];
         end
      end
   end

   assign driver_monitor_alarm = alarm_q;
   assign alarm_oe             = oe_q;
   assign irq                  = irq_q;
   assign irq_oe               = irq_oe_q;
   assign line_cfg             = cfg_q;
   assign hrdata               = rdata_q;
   assign hreadyout            = ready_q;
   assign hresp                = 1'b0;

   //////////////////////////////////////////////////////////////////////////
   // checks
   property p_alarm_raise;
      @(posedge hclk) disable iff (!hresetn)
      (tx_en && !seen_now[0] && !soft_rst && gap_q[0] == GAP_W'(ALARM_LIMIT)) |=> alarm_q[0];
   endproperty
   a_alarm_raise: assert property (p_alarm_raise) else $error("alarm not raised after limit");

   property p_alarm_not_early;
      @(posedge hclk) disable iff (!hresetn)
      $rose(alarm_q[0]) |-> $past(gap_q[0]) == GAP_W'(ALARM_LIMIT);
   endproperty
   a_alarm_not_early: assert property (p_alarm_not_early) else $error("alarm raised early");

   property p_alarm_drop;
      @(posedge hclk) disable iff (!hresetn)
      (tx_en && seen_now[0]) |=> !alarm_q[0] && gap_q[0] == '0;
   endproperty
   a_alarm_drop: assert property (p_alarm_drop) else $error("alarm held after pulse");

   property p_alarm_hold;
      @(posedge hclk) disable iff (!hresetn)
      (alarm_q[0] && !seen_now[0] && !soft_rst) |=> alarm_q[0];
   endproperty
   a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped without pulse");

   property p_soft_reset;
      @(posedge hclk) disable iff (!hresetn)
      (!hw_reset_n && hwrst_cnt_q == HWRST_W'(HW_RESET_CYC)) |=>
         global_q == GLOBAL_RST && mask_q == IRQ_RST && alarm_q == '0;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("long reset did not reload");

   property p_format;
      @(posedge hclk) disable iff (!hresetn)
      !host_mode |=> cfg_q.single_rail == $past(straps.rail_format_select);
   endproperty
   a_format: assert property (p_format) else $error("format strap not applied");

   property p_rx_term;
      @(posedge hclk) disable iff (!hresetn)
      (!host_mode || global_q[GC_RX_OVR]) |=>
         cfg_q.rx_term_int == {NUM_CH{$past(straps.rx_termination_strap)}};
   endproperty
   a_rx_term: assert property (p_rx_term) else $error("rx termination not from strap");

   property p_tx_term;
      @(posedge hclk) disable iff (!hresetn)
      !host_mode |=> cfg_q.tx_term_int == {NUM_CH{$past(straps.tx_termination_strap)}};
   endproperty
   a_tx_term: assert property (p_tx_term) else $error("tx termination not from strap");

   property p_impedance;
      @(posedge hclk) disable iff (!hresetn)
      (!host_mode && straps.impedance_code_msb && !straps.impedance_code_lsb) |=>
         cfg_q.impedance == IMP_75;
   endproperty
   a_impedance: assert property (p_impedance) else $error("impedance decode wrong");

   property p_gauge;
      @(posedge hclk) disable iff (!hresetn)
      !host_mode |=> cfg_q.gauge26 == $past(straps.gauge_strap);
   endproperty
   a_gauge: assert property (p_gauge) else $error("gauge strap not applied");

   property p_tristate;
      @(posedge hclk) disable iff (!hresetn)
      !in_circuit_tristate_n |=> alarm_oe == '0 && !irq_oe;
   endproperty
   a_tristate: assert property (p_tristate) else $error("outputs driven in test");

   property p_host_regs;
      @(posedge hclk) disable iff (!hresetn)
      (host_mode && !global_q[GC_RX_OVR]) |=>
         cfg_q.rx_term_int == $past(rx_reg_q) && cfg_q.tx_term_int == $past(tx_reg_q);
   endproperty
   a_host_regs: assert property (p_host_regs) else $error("host mode ignored registers");

endmodule

`default_nettype wire

// File: dv/liu_board_model.sv
/*
 * board straps and framer model: strap levels and transmit pulses.
 * assumes the bench picks the strap code and which channels go quiet.
 */
`timescale 1ns/100ps
`default_nettype none

module liu_board_model
   import liu_pkg::*;
(
   // clock
   input  wire logic              hclk,
   // bench controls
   input  wire logic [NUM_CH-1:0] silent,
   input  wire logic [5:0]        strap_code,
   // pins toward the block
   output logic [NUM_CH-1:0]      tx_pulse,
   output strap_s                 straps
);
   // factory test input grounded in normal operation
   localparam logic FACTORY_TEST = 1'b0;

   logic [2:0] ph_q = 3'h0;

   initial tx_pulse = '0;

   // half-duty pulses keep active channels far below the alarm limit
   always @(posedge hclk) begin
      ph_q     <= ph_q + 3'h1;
      tx_pulse <= ~silent & {NUM_CH{ph_q[2]}};
      straps   <= strap_s'(strap_code);
   end
endmodule
`default_nettype wire

// File: dv/liu_alarm_strap_control_test.sv
/*
 * self-checking bench: ahb-lite master, register model, strap and alarm checks.
 * assumes liu_board_model stands on the line side.
 */
`timescale 1ns/100ps
`default_nettype none

module liu_alarm_strap_control_test
   import liu_pkg::*;
;
   localparam int DIV = 4;

   logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic              host_mode, hw_reset_n, tristate_n, irq, irq_oe;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   logic [31:0]       haddr, hwdata, hrdata, rd;
   logic [NUM_CH-1:0] tx_pulse, silent, alarm, alarm_oe;
   logic [5:0]        sc;
   logic [7:0]        seed, m_rx, m_tx, m_alarm;
   logic [4:0]        m_glb;
   logic [15:0]       m_stat, m_mask;
   strap_s            straps;
   line_cfg_s         line_cfg;
   int                n_fail, checks_done;

   liu_board_model u_board (.hclk(hclk), .silent(silent), .strap_code(sc),
      .tx_pulse(tx_pulse), .straps(straps));

   liu_alarm_strap_control #(.TX_DIV(DIV)) u_dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .tx_pulse(tx_pulse), .host_mode(host_mode), .hw_reset_n(hw_reset_n),
      .in_circuit_tristate_n(tristate_n), .straps(straps), .driver_monitor_alarm(alarm),
      .alarm_oe(alarm_oe), .irq(irq), .irq_oe(irq_oe), .line_cfg(line_cfg));

//////////////////////////////////////////////////////////////////////////////

   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction

   function automatic logic [31:0] mexp(input logic [7:0] a);
      case (a)
         REG_GLOBAL:   return {27'h0, m_glb};
         REG_RX_TERM:  return {24'h0, m_rx};
         REG_TX_TERM:  return {24'h0, m_tx};
         REG_ALARM:    return {24'h0, m_alarm};
         REG_IRQ_STAT: return {16'h0, m_stat};
         REG_IRQ_MASK: return {16'h0, m_mask};
         default:      return 32'h0;
      endcase
   endfunction

   // strap bits: 5 format, 4 rx term, 3 tx term, 2:1 impedance, 0 gauge
   function automatic logic [19:0] cfg_exp();
      if (!host_mode) return {sc[5], sc[0], sc[2:1], {8{sc[4]}}, {8{sc[3]}}};
      return {m_glb[1], m_glb[2], m_glb[4:3], m_glb[0] ? {8{sc[4]}} : m_rx, m_tx};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= 3'b010;
      haddr  <= {24'h0, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, rd);
      case (a)
         REG_GLOBAL:   m_glb = d[4:0];
         REG_RX_TERM:  m_rx = d[7:0];
         REG_TX_TERM:  m_tx = d[7:0];
         REG_IRQ_STAT: m_stat &= ~d[15:0];
         REG_IRQ_MASK: m_mask = d[15:0];
         default: ;
      endcase
   endtask

   task automatic rdc(input logic [7:0] a);
      bus(1'b0, a, 32'h0, rd);
      chk(rd, mexp(a));
   endtask

   // config is registered twice (straps, then block), so allow four edges
   task automatic cfgchk();
      repeat (4) @(posedge hclk);
      chk({12'h0, line_cfg}, {12'h0, cfg_exp()});
   endtask

   task automatic final_report();
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

//////////////////////////////////////////////////////////////////////////////

   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   // whole run is under two thousand cycles
   initial begin
      repeat (20000) @(posedge hclk);
      n_fail++;
      final_report();
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      host_mode = 1'b0;
      hw_reset_n = 1'b1;
      tristate_n = 1'b1;
      silent = '0;
      sc = 6'h00;
      seed = 8'd98;
      {m_glb, m_rx, m_tx, m_alarm, m_stat, m_mask} = '0;
      n_fail = 0;
      checks_done = 0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      // 0x18 is unmapped and reads zero
      for (int a = 0; a <= 24; a += 4) rdc(8'(a));
      chk(32'(hresp), 32'h0);
      for (int i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         sc <= (i < 4) ? {seed[5:3], 2'(i), seed[0]} : seed[5:0];
         cfgchk();
      end
      host_mode <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         wr(REG_GLOBAL, {27'h0, seed[4:0]});
         wr(REG_RX_TERM, {24'h0, lfsr(seed)});
         wr(REG_TX_TERM, {24'h0, ~seed});
         sc <= ~sc;
         cfgchk();
         rdc(REG_RX_TERM);
      end
      wr(REG_IRQ_MASK, 32'h0000_0001);
      silent <= 8'h81;
      repeat (500) @(posedge hclk);
      chk(32'(alarm), 32'h0);
      repeat (30) @(posedge hclk);
      m_alarm = 8'h81;
      m_stat = 16'h0081;
      chk(32'(alarm), 32'h81);
      chk(32'(irq), 32'h1);
      rdc(REG_ALARM);
      rdc(REG_IRQ_STAT);
      wr(REG_IRQ_MASK, 32'h0);
      repeat (2) @(posedge hclk);
      chk(32'(irq), 32'h0);
      wr(REG_IRQ_MASK, 32'h0000_0100);
      silent <= 8'h80;
      repeat (4 * DIV) @(posedge hclk);
      m_alarm = 8'h80;
      m_stat |= 16'h0100;
      chk(32'(alarm), 32'h80);
      chk(32'(irq), 32'h1);
      rdc(REG_IRQ_STAT);
      wr(REG_IRQ_STAT, 32'h0000_ffff);
      repeat (2) @(posedge hclk);
      chk(32'(irq), 32'h0);
      rdc(REG_IRQ_STAT);
      tristate_n <= 1'b0;
      repeat (2) @(posedge hclk);
      chk(32'({alarm_oe, irq_oe}), 32'h0);
      tristate_n <= 1'b1;
      repeat (2) @(posedge hclk);
      chk(32'({alarm_oe, irq_oe}), 32'h1ff);
      // a short low must leave the registers alone
      hw_reset_n <= 1'b0;
      repeat (300) @(posedge hclk);
      hw_reset_n <= 1'b1;
      rdc(REG_TX_TERM);
      rdc(REG_IRQ_MASK);
      hw_reset_n <= 1'b0;
      repeat (HW_RESET_CYC + 4) @(posedge hclk);
      hw_reset_n <= 1'b1;
      {m_glb, m_rx, m_tx, m_alarm, m_stat, m_mask} = '0;
      for (int a = 0; a <= 20; a += 4) rdc(8'(a));
      cfgchk();
      final_report();
   end
endmodule
`default_nettype wire
